// file: anr_mmd_model.sv
// Purpose: behavioural far side of the indirect device window
// Assumes: read data depends only on selected device and address, answered at once
// Notes: a fixed pattern stands in for real device registers; strobes are counted
module anr_mmd_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [anr_pkg::CTL_DEV_W-1:0] mmd_dev,
  input wire logic [15:0] mmd_addr,
  input wire logic mmd_wr,
  input wire logic mmd_rd,
  output logic [15:0] mmd_rdata,
  output logic [7:0] wr_count,
  output logic [7:0] rd_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // pattern mixes device and address so a wrong selection shows up
  assign mmd_rdata = mmd_addr ^ {11'h000, mmd_dev} ^ 16'ha5c3;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_count <= 8'h00;
      rd_count <= 8'h00;
    end else begin
      wr_count <= wr_count + {7'h00, mmd_wr};
      rd_count <= rd_count + {7'h00, mmd_rd};
    end
  end
endmodule : anr_mmd_model

// file: anr_pkg.sv
// Purpose: constants for the negotiation expansion / next page / indirect access register slice
// Assumes: register indices as printed; byte address is four times the index
// Notes: fields are 16 bits wide in the low half of each 32-bit apb word
package anr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [3:0] IDX_PARTNER_ABILITY = 4'h5;
  localparam logic [3:0] IDX_EXPANSION = 4'h6;
  localparam logic [3:0] IDX_LOCAL_NP = 4'h7;
  localparam logic [3:0] IDX_PARTNER_NP = 4'h8;
  localparam logic [3:0] IDX_INDIRECT_CTL = 4'hd;
  localparam logic [3:0] IDX_INDIRECT_DATA = 4'he;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam int unsigned EXP_PD_FAULT = 4;
  localparam int unsigned EXP_LP_NP_ABLE = 3;
  localparam int unsigned EXP_NP_ABLE = 2;
  localparam int unsigned EXP_PAGE_RX = 1;
  localparam int unsigned EXP_LP_AN_ABLE = 0;
  localparam int unsigned NP_MORE = 15;
  localparam int unsigned NP_RSVD = 14;
  localparam int unsigned NP_MSG_PAGE = 13;
  localparam int unsigned NP_COMPLY = 12;
  localparam int unsigned NP_TOGGLE = 11;
  localparam int unsigned NP_MSG_W = 11;
  localparam logic [10:0] NP_MSG_RESET = 11'h001;
  localparam logic [15:0] LOCAL_NP_RESET = 16'h2001;
  localparam logic [15:0] LOCAL_NP_WMASK = 16'hb7ff;
  localparam int unsigned CTL_OP_HI = 15;
  localparam int unsigned CTL_OP_LO = 14;
  localparam int unsigned CTL_DEV_W = 5;
  typedef enum logic [1:0] {
    ANR_OP_REG = 2'b00,
    ANR_OP_DATA = 2'b01,
    ANR_OP_DATA_INC_RW = 2'b10,
    ANR_OP_DATA_INC_W = 2'b11
  } anr_op_e;
endpackage : anr_pkg

// file: anr_regs.sv
// Purpose: apb register slice for negotiation expansion, next page words and indirect device window
// Assumes: single clock core_clk at 25 MHz, synchronous active-low rst_n, event inputs synchronous
// Notes: every apb transfer takes one wait cycle; the indirect space answers combinationally on mmd_rdata
// How it works
// - partner ability selector reads fixed read-only 00001, also its reset value
// - parallel detection fault sets a latched-high read-only expansion flag, reset zero
// - new page from partner sets latched-high read-only page received flag
// - expansion bit shows partner next page ability, read only
// - expansion bit shows own next page ability, reads one from reset
// - lowest expansion bit shows partner negotiation ability, reset zero
// - upper expansion bits are reserved and read zero
// - local next page top bit writable more-pages flag, reset zero
// - writable comply flag in local next page word, reset zero
// - local next page toggle is read only, last transmitted toggle, reset zero
// - partner next page word fully read only, reset zero
// - partner toggle bit reported as received, one means previous toggle was zero
// - indirect control holds two-bit operation field in top bits, reset zero
// - indirect control holds five-bit device address in low bits, middle reserved
// - operation zero makes the data window access the register address
// - nonzero operation accesses data and post-increments per chosen mode
module anr_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [anr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pd_fault_event,
  input wire logic page_rx_event,
  input wire logic partner_np_able,
  input wire logic partner_an_able,
  input wire logic tx_toggle,
  input wire logic partner_np_load,
  input wire logic [15:0] partner_np_word,
  output logic [15:0] local_np_word,
  output logic [anr_pkg::CTL_DEV_W-1:0] mmd_dev,
  output logic [15:0] mmd_addr,
  output logic [15:0] mmd_wdata,
  output logic mmd_wr,
  output logic mmd_rd,
  input wire logic [15:0] mmd_rdata
);

  // address decode, shared by read mux, write path and error answer
  function automatic logic [3:0] reg_idx(input logic [anr_pkg::ADDR_W-1:0] a);
    logic [3:0] i;
    i = 4'h0;
    if (a[1:0] == 2'b00 && a[anr_pkg::ADDR_W-1:6] == '0) begin
      i = a[5:2];
    end
    return i;
  endfunction : reg_idx

  function automatic logic is_mapped(input logic [3:0] i);
    return (i == anr_pkg::IDX_PARTNER_ABILITY) || (i == anr_pkg::IDX_EXPANSION) ||
           (i == anr_pkg::IDX_LOCAL_NP) || (i == anr_pkg::IDX_PARTNER_NP) ||
           (i == anr_pkg::IDX_INDIRECT_CTL) || (i == anr_pkg::IDX_INDIRECT_DATA);
  endfunction : is_mapped

  logic [3:0] idx;
  logic done;
  logic wr_done;
  logic rd_done;
  logic pd_fault;
  logic page_rx;
  logic np_able;
  logic [15:0] partner_np;
  logic [1:0] ctl_op;
  logic [15:0] next_prdata;
  logic data_op;
  logic inc_now;
  logic inc_pend;

  assign idx = reg_idx(paddr);
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign data_op = (ctl_op != anr_pkg::ANR_OP_REG);

  // one wait cycle: pready rises in the second access cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !is_mapped(idx);
        prdata <= pwrite ? 32'h0000_0000 : {16'h0000, next_prdata};
      end
    end
  end

  always_comb begin
    next_prdata = 16'h0000;
    case (idx)
      anr_pkg::IDX_PARTNER_ABILITY: next_prdata = {11'h000, anr_pkg::SELECTOR_8023};
      anr_pkg::IDX_EXPANSION: begin
        next_prdata[anr_pkg::EXP_PD_FAULT] = pd_fault;
        next_prdata[anr_pkg::EXP_LP_NP_ABLE] = partner_np_able;
        next_prdata[anr_pkg::EXP_NP_ABLE] = np_able;
        next_prdata[anr_pkg::EXP_PAGE_RX] = page_rx;
        next_prdata[anr_pkg::EXP_LP_AN_ABLE] = partner_an_able;
      end
      anr_pkg::IDX_LOCAL_NP: next_prdata = local_np_word;
      anr_pkg::IDX_PARTNER_NP: next_prdata = partner_np;
      anr_pkg::IDX_INDIRECT_CTL: next_prdata = {ctl_op, 9'h000, mmd_dev};
      anr_pkg::IDX_INDIRECT_DATA: next_prdata = data_op ? mmd_rdata : mmd_addr;
      default: next_prdata = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      np_able <= 1'b1;
    end else begin
      np_able <= 1'b1;
    end
  end

  // set wins; only the value actually read is cleared
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pd_fault <= 1'b0;
      page_rx <= 1'b0;
    end else begin
      pd_fault <= pd_fault_event ||
        (pd_fault && !(rd_done && idx == anr_pkg::IDX_EXPANSION && prdata[anr_pkg::EXP_PD_FAULT]));
      page_rx <= page_rx_event ||
        (page_rx && !(rd_done && idx == anr_pkg::IDX_EXPANSION && prdata[anr_pkg::EXP_PAGE_RX]));
    end
  end

  // local next page word; toggle and reserved bit are never written by software
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      local_np_word <= anr_pkg::LOCAL_NP_RESET;
    end else begin
      if (wr_done && idx == anr_pkg::IDX_LOCAL_NP) begin
        local_np_word[anr_pkg::NP_MORE] <= pwdata[anr_pkg::NP_MORE];
        local_np_word[anr_pkg::NP_MSG_PAGE] <= pwdata[anr_pkg::NP_MSG_PAGE];
        local_np_word[anr_pkg::NP_COMPLY] <= pwdata[anr_pkg::NP_COMPLY];
        local_np_word[anr_pkg::NP_MSG_W-1:0] <= pwdata[anr_pkg::NP_MSG_W-1:0];
      end
      local_np_word[anr_pkg::NP_RSVD] <= 1'b0;
      local_np_word[anr_pkg::NP_TOGGLE] <= tx_toggle;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      partner_np <= 16'h0000;
    end else if (partner_np_load) begin
      partner_np <= partner_np_word;
    end
  end

  // post increment applies only to data operations
  always_comb begin
    case (ctl_op)
      anr_pkg::ANR_OP_DATA_INC_RW: inc_now = done;
      anr_pkg::ANR_OP_DATA_INC_W: inc_now = wr_done;
      default: inc_now = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_op <= anr_pkg::ANR_OP_REG;
      mmd_dev <= '0;
      mmd_addr <= 16'h0000;
      mmd_wdata <= 16'h0000;
      mmd_wr <= 1'b0;
      mmd_rd <= 1'b0;
      inc_pend <= 1'b0;
    end else begin
      mmd_wr <= 1'b0;
      mmd_rd <= 1'b0;
      inc_pend <= 1'b0;
      // step after the strobe, so the far side sees the accessed address
      if (inc_pend) begin
        mmd_addr <= mmd_addr + 16'h0001;
      end
      if (wr_done && idx == anr_pkg::IDX_INDIRECT_CTL) begin
        ctl_op <= pwdata[anr_pkg::CTL_OP_HI:anr_pkg::CTL_OP_LO];
        mmd_dev <= pwdata[anr_pkg::CTL_DEV_W-1:0];
      end
      if (done && idx == anr_pkg::IDX_INDIRECT_DATA) begin
        if (!data_op) begin
          if (pwrite) begin
            mmd_addr <= pwdata[15:0];
          end
        end else begin
          mmd_wr <= pwrite;
          mmd_rd <= !pwrite;
          mmd_wdata <= pwrite ? pwdata[15:0] : mmd_wdata;
          inc_pend <= inc_now;
        end
      end
    end
  end

  // checks
  logic [1:0] op_d;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      op_d <= 2'b00;
    end else begin
      op_d <= ctl_op;
    end
  end

  property p_selector;
    @(posedge core_clk) disable iff (!rst_n)
      rd_done && idx == anr_pkg::IDX_PARTNER_ABILITY |-> prdata[4:0] == 5'h01 && prdata[31:5] == '0;
  endproperty
  a_selector: assert property (p_selector) else $error("selector not 00001");

  property p_pd_set;
    @(posedge core_clk) disable iff (!rst_n) pd_fault_event |=> pd_fault;
  endproperty
  a_pd_set: assert property (p_pd_set) else $error("fault flag not set");

  property p_page_set;
    @(posedge core_clk) disable iff (!rst_n) page_rx_event |=> page_rx;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page flag not set");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      page_rx && !rd_done ##1 !page_rx_event |-> page_rx;
  endproperty
  a_hold: assert property (p_hold) else $error("latched flag dropped without read");

  property p_clear;
    @(posedge core_clk) disable iff (!rst_n)
      rd_done && idx == anr_pkg::IDX_EXPANSION && prdata[anr_pkg::EXP_PAGE_RX] && !page_rx_event |=> !page_rx;
  endproperty
  a_clear: assert property (p_clear) else $error("latched flag not cleared by read");

  property p_exp_read;
    @(posedge core_clk) disable iff (!rst_n)
      rd_done && idx == anr_pkg::IDX_EXPANSION |-> prdata[31:5] == '0 && prdata[2];
  endproperty
  a_exp_read: assert property (p_exp_read) else $error("expansion reserved or able bit wrong");

  property p_lp_able;
    @(posedge core_clk) disable iff (!rst_n)
      psel && penable && !pready && !pwrite && idx == anr_pkg::IDX_EXPANSION
      |=> prdata[3] == $past(partner_np_able) && prdata[0] == $past(partner_an_able);
  endproperty
  a_lp_able: assert property (p_lp_able) else $error("partner ability bits wrong");

  property p_np_write;
    @(posedge core_clk) disable iff (!rst_n)
      wr_done && idx == anr_pkg::IDX_LOCAL_NP
      |=> (local_np_word & anr_pkg::LOCAL_NP_WMASK) == ($past(pwdata[15:0]) & anr_pkg::LOCAL_NP_WMASK)
          && !local_np_word[14];
  endproperty
  a_np_write: assert property (p_np_write) else $error("local next page write wrong");

  property p_toggle;
    @(posedge core_clk) disable iff (!rst_n) ##1 local_np_word[11] == $past(tx_toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not tracking");

  property p_lp_load;
    @(posedge core_clk) disable iff (!rst_n) partner_np_load |=> partner_np == $past(partner_np_word);
  endproperty
  a_lp_load: assert property (p_lp_load) else $error("partner word not stored");

  property p_inc;
    @(posedge core_clk) disable iff (!rst_n)
      done && idx == anr_pkg::IDX_INDIRECT_DATA && (ctl_op == 2'b10 || (ctl_op == 2'b11 && pwrite))
      |=> ##1 mmd_addr == $past(mmd_addr, 2) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("post increment missing");

  property p_no_inc;
    @(posedge core_clk) disable iff (!rst_n)
      done && idx == anr_pkg::IDX_INDIRECT_DATA && (ctl_op == 2'b01 || (ctl_op == 2'b11 && !pwrite))
      |=> ##1 mmd_addr == $past(mmd_addr, 2);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("unexpected increment");

  property p_reg_mode;
    @(posedge core_clk) disable iff (!rst_n)
      wr_done && idx == anr_pkg::IDX_INDIRECT_DATA && ctl_op == 2'b00
      |=> mmd_addr == $past(pwdata[15:0]) && !mmd_wr;
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register mode write wrong");

  property p_ctl;
    @(posedge core_clk) disable iff (!rst_n)
      wr_done && idx == anr_pkg::IDX_INDIRECT_CTL
      |=> ctl_op == $past(pwdata[15:14]) && mmd_dev == $past(pwdata[4:0]);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control write wrong");

  property p_strobe;
    @(posedge core_clk) disable iff (!rst_n)
      done && idx == anr_pkg::IDX_INDIRECT_DATA && ctl_op != 2'b00
      |=> mmd_wr == $past(pwrite) && mmd_rd == !$past(pwrite) && mmd_addr == $past(mmd_addr);
  endproperty
  a_strobe: assert property (p_strobe) else $error("window strobe or address wrong");

  property p_pd_hold;
    @(posedge core_clk) disable iff (!rst_n) pd_fault && !rd_done |=> pd_fault;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("fault flag dropped without read");

  property p_pd_clear;
    @(posedge core_clk) disable iff (!rst_n)
      rd_done && idx == anr_pkg::IDX_EXPANSION && prdata[anr_pkg::EXP_PD_FAULT] && !pd_fault_event
      |=> !pd_fault;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("fault flag not cleared by read");

  property p_partner_rd;
    @(posedge core_clk) disable iff (!rst_n)
      psel && penable && !pready && !pwrite && idx == anr_pkg::IDX_PARTNER_NP
      |=> prdata == {16'h0000, $past(partner_np)};
  endproperty
  a_partner_rd: assert property (p_partner_rd) else $error("partner word read wrong");

  property p_local_rd;
    @(posedge core_clk) disable iff (!rst_n)
      psel && penable && !pready && !pwrite && idx == anr_pkg::IDX_LOCAL_NP
      |=> prdata == {16'h0000, $past(local_np_word)};
  endproperty
  a_local_rd: assert property (p_local_rd) else $error("local word read wrong");

  property p_window_rd;
    @(posedge core_clk) disable iff (!rst_n)
      psel && penable && !pready && !pwrite && idx == anr_pkg::IDX_INDIRECT_DATA
      |=> prdata[15:0] == ($past(data_op) ? $past(mmd_rdata) : $past(mmd_addr));
  endproperty
  a_window_rd: assert property (p_window_rd) else $error("window read wrong");

  property p_ctl_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      rd_done && idx == anr_pkg::IDX_INDIRECT_CTL |-> prdata[31:16] == '0 && prdata[13:5] == '0;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits not zero");

  c_wr_only: cover property (@(posedge core_clk) disable iff (!rst_n) mmd_wr && op_d == 2'b11);
  c_page_read: cover property (@(posedge core_clk) disable iff (!rst_n)
    rd_done && idx == anr_pkg::IDX_EXPANSION && prdata[1]);
  c_inc_rw: cover property (@(posedge core_clk) disable iff (!rst_n) mmd_rd && op_d == 2'b10);
  c_set_vs_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
    rd_done && idx == anr_pkg::IDX_EXPANSION && page_rx_event);

endmodule : anr_regs

// file: tb.sv
// Purpose: self-checking bench for the negotiation and indirect access register slice
// Assumes: apb master with one request at a time, partner pattern model on the window
// Notes: apb answers are sampled at the rising edge; local word, device, address and wdata at the falling edge once the register update has landed
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [anr_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, mmd_wr, mmd_rd;
  logic pd_ev = 1'b0, pg_ev = 1'b0, lp_np = 1'b0, lp_an = 1'b0, tgl = 1'b0, np_load = 1'b0;
  logic [15:0] np_word = 16'h0000;
  logic [15:0] local_np_word, mmd_addr, mmd_wdata, mmd_rdata;
  logic [anr_pkg::CTL_DEV_W-1:0] mmd_dev;
  logic [7:0] wr_cnt, rd_cnt;
  int n_fail = 0;
  int checks_done = 0;

  anr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_fault_event(pd_ev), .page_rx_event(pg_ev), .partner_np_able(lp_np), .partner_an_able(lp_an),
    .tx_toggle(tgl), .partner_np_load(np_load), .partner_np_word(np_word), .local_np_word(local_np_word),
    .mmd_dev(mmd_dev), .mmd_addr(mmd_addr), .mmd_wdata(mmd_wdata), .mmd_wr(mmd_wr), .mmd_rd(mmd_rd),
    .mmd_rdata(mmd_rdata));
  anr_mmd_model mmd (.core_clk(core_clk), .rst_n(rst_n), .mmd_dev(mmd_dev), .mmd_addr(mmd_addr),
    .mmd_wr(mmd_wr), .mmd_rd(mmd_rd), .mmd_rdata(mmd_rdata), .wr_count(wr_cnt), .rd_count(rd_cnt));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  // holds the request until pready is sampled high, then releases
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 16'h0000, r, e);
    chk("read data", {16'h0000, exp}, r);
    chk("pslverr", 32'h0000_0000, {31'h0, e});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  function automatic logic [15:0] pat(input logic [15:0] a, input logic [4:0] d);
    return a ^ {11'h000, d} ^ 16'ha5c3;
  endfunction : pat

  task automatic t_reset_values;
    rd(12'h014, 16'h0001);
    rd(12'h018, 16'h0004);
    rd(12'h01c, 16'h2001);
    rd(12'h020, 16'h0000);
    rd(12'h034, 16'h0000);
    rd(12'h038, 16'h0000);
  endtask : t_reset_values

  task automatic t_read_only;
    wr(12'h014, 16'hffff);
    rd(12'h014, 16'h0001);
    wr(12'h018, 16'hffff);
    rd(12'h018, 16'h0004);
    wr(12'h020, 16'hffff);
    rd(12'h020, 16'h0000);
  endtask : t_read_only

  task automatic t_local_np;
    wr(12'h01c, 16'hffff);
    rd(12'h01c, 16'hb7ff);
    @(negedge core_clk);
    chk("local word", 32'h0000_b7ff, {16'h0000, local_np_word});
    @(posedge core_clk);
    tgl <= 1'b1;
    rd(12'h01c, 16'hbfff);
    wr(12'h01c, 16'h0000);
    rd(12'h01c, 16'h0800);
    tgl <= 1'b0;
  endtask : t_local_np

  task automatic t_expansion;
    lp_np <= 1'b1;
    lp_an <= 1'b1;
    rd(12'h018, 16'h000d);
    pd_ev <= 1'b1;
    pg_ev <= 1'b1;
    @(posedge core_clk);
    pd_ev <= 1'b0;
    pg_ev <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(12'h018, 16'h001f);
    rd(12'h018, 16'h000d);
    pd_ev <= 1'b1;
    rd(12'h018, 16'h001d);
    pd_ev <= 1'b0;
    rd(12'h018, 16'h001d);
    rd(12'h018, 16'h000d);
    lp_an <= 1'b0;
    lp_np <= 1'b0;
    rd(12'h018, 16'h0004);
  endtask : t_expansion

  task automatic t_partner_np;
    np_word <= 16'hfa5a;
    np_load <= 1'b1;
    @(posedge core_clk);
    np_load <= 1'b0;
    rd(12'h020, 16'hfa5a);
    wr(12'h020, 16'h0000);
    rd(12'h020, 16'hfa5a);
  endtask : t_partner_np

  task automatic t_indirect;
    logic [15:0] a;
    a = 16'h0010;
    wr(12'h034, 16'hffff);
    rd(12'h034, 16'hc01f);
    @(negedge core_clk);
    chk("device", 32'h0000_001f, {27'h0, mmd_dev});
    wr(12'h034, 16'h0003);
    wr(12'h038, a);
    rd(12'h038, a);
    for (int op = 1; op < 4; op++) begin
      wr(12'h034, {op[1:0], 14'h0003});
      rd(12'h038, pat(a, 5'h03));
      a = a + ((op == 2) ? 16'h0001 : 16'h0000);
      wr(12'h038, 16'h1230 + 16'(op));
      a = a + ((op >= 2) ? 16'h0001 : 16'h0000);
      // the address steps one cycle after the write strobe
      repeat (2) @(negedge core_clk);
      chk("address", {16'h0000, a}, {16'h0000, mmd_addr});
      chk("wdata", 32'h0000_1230 + op, {16'h0000, mmd_wdata});
    end
    rd(12'h034, 16'hc003);
    repeat (3) @(posedge core_clk);
    chk("writes", 32'h0000_0003, {24'h0, wr_cnt});
    chk("reads", 32'h0000_0003, {24'h0, rd_cnt});
  endtask : t_indirect

  task automatic t_refused;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h03c, 16'h0000, r, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, r);
    apb(1'b1, 12'h015, 16'hffff, r, e);
    chk("misaligned err", 32'h0000_0001, {31'h0, e});
    rd(12'h01c, 16'h0000);
  endtask : t_refused

  // a reset in mid-run must bring back the local next page, control, window address and partner word reset values
  task automatic t_mid_reset;
    wr(12'h01c, 16'h9abc);
    rd(12'h01c, 16'h92bc);
    wr(12'h034, 16'h8005);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(12'h01c, 16'h2001);
    rd(12'h034, 16'h0000);
    rd(12'h038, 16'h0000);
    rd(12'h020, 16'h0000);
  endtask : t_mid_reset

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_read_only();
    t_local_np();
    t_expansion();
    t_partner_np();
    t_indirect();
    t_refused();
    t_mid_reset();
    final_report();
  end

  // whole run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
endmodule : tb
